// ---- core/charger_control_config_regs.sv ----
// module: charger control register bank and decoded power-stage controls
`timescale 1ns/100ps
// Contract
// [RULE1] bit2 set disables input voltage loop
// [RULE2] bit1 adds 384mV when not charging
// [RULE3] reverse turbo draws battery on overcurrent
// [RULE4] host avoids turbo in direct/autonomous/low battery; host model and gate cover direct mode only
// [RULE5] comparator debounce code selects delay
// [RULE6] exit learn when battery below minimum
// [RULE7] learn mode needs pin low, battery present
// [RULE8] bit11 enables reverse output supply
// [RULE9] bit10 enables supplemental support
// [RULE10] bits9:7 override switching frequency
// [RULE11] host writes frequency back to keep it
// [RULE12] bit6 forces battery FET gate off
// [RULE13] monitor disable only in battery-only operation
// [RULE14] bit4 selects adapter or battery monitor
// [RULE15] fields read back, reset to defaults
module charger_control_config_regs
   import charger_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic charging,
   input wire logic hybrid_cfg,
   input wire logic adapter_overlimit,
   input wire logic adapter_present,
   input wire logic battery_present,
   input wire logic battery_absent_pin,
   input wire logic narrow_voltage_direct_charge,
   input wire logic bat_below_min_sys,
   input wire logic cmp_raw,
   output logic vin_loop_en,
   output logic [8:0] sys_offset_mv_out,
   output logic reverse_turbo_active,
   output logic cmp_asserted,
   output logic learn_active_out,
   output logic reverse_output_supply,
   output logic supplemental_en,
   output logic [10:0] switch_khz,
   output logic battery_fet_gate_off,
   output logic turbo_allowed,
   output logic current_monitor_function,
   output logic mon_sel_battery
);
   import charger_cfg_pkg::*;
   // ==========================================================
   // pin synchronisers
   logic [1:0] bgone_s_r; // battery absent pin sync
   logic [1:0] cmp_s_r; // comparator pin sync
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bgone_s_r <= 2'h0;
         cmp_s_r <= 2'h0;
      end else begin
         bgone_s_r <= {bgone_s_r[0], battery_absent_pin};
         cmp_s_r <= {cmp_s_r[0], cmp_raw};
      end
   end
   wire bgone_sync = bgone_s_r[1];
   // ==========================================================
   // register storage
   logic [15:0] ctrl0_r; // first control register
   logic [15:0] ctrl1_r; // second control register
   wire sel0 = (reg_addr == ctrl_zero_addr); // decode first
   wire sel1 = (reg_addr == ctrl_one_addr); // decode second
   // only the low three bits of the first register live here
   wire [15:0] ctrl0_wmask = 16'h0007;
   // [RULE15] writes land, reset gives defaults
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl0_r <= ctrl_zero_rst;
         ctrl1_r <= ctrl_one_rst;
      end else begin
         if (reg_wr && sel0) ctrl0_r <= reg_wdata & ctrl0_wmask;
         if (reg_wr && sel1) ctrl1_r <= reg_wdata & ctrl_one_mask;
      end
   end
   // readback mux; unmapped addresses read zero
   wire [15:0] rd_mux = sel0 ? ctrl0_r : sel1 ? ctrl1_r : 16'h0000;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) reg_rdata <= 16'h0000;
      else if (reg_rd) reg_rdata <= rd_mux;
   end
   // ==========================================================
   // field decode
   wire f_vin_off = ctrl0_r[vin_reg_off_bit];
   wire f_sys_off = ctrl0_r[sys_offset_bit];
   wire f_rturbo = ctrl0_r[rev_turbo_bit];
   wire [1:0] f_dbnc = ctrl1_r[dbnc_hi:dbnc_lo];
   wire f_exit_learn = ctrl1_r[exit_learn_bit];
   wire f_learn = ctrl1_r[learn_bit];
   wire [2:0] f_freq = ctrl1_r[freq_hi:freq_lo];
   wire f_bfet_off = ctrl1_r[bfet_off_bit];
   wire f_mon_off = ctrl1_r[mon_off_bit];
   // [RULE1] loop runs while bit clear
   wire vin_en_nxt = !f_vin_off;
   // [RULE2] offset only when idle
   wire [8:0] off_nxt = (f_sys_off && !charging) ? 9'(sys_offset_mv) : 9'h000;
   // [RULE3] reverse on overcurrent in hybrid
   // [RULE4] host keeps bit clear in direct mode; we also gate it
   wire rturbo_nxt = f_rturbo && hybrid_cfg && adapter_overlimit && !narrow_voltage_direct_charge;
   // [RULE10] frequency code lookup; code 5 unlisted, holds 808
   wire [10:0] khz_nxt = (f_freq == freq_1420) ? khz_1420 :
                         (f_freq == freq_1180) ? khz_1180 :
                         (f_freq == freq_1020) ? khz_1020 :
                         (f_freq == freq_890) ? khz_890 :
                         (f_freq == freq_656) ? khz_656 :
                         (f_freq == freq_600) ? khz_600 : khz_808;
   // [RULE13] adapter forces monitor on
   wire mon_fn_nxt = adapter_present || !f_mon_off;
   // ==========================================================
   // learn mode sequencer
   learn_st_t learn_r;
   learn_st_t learn_nxt;
   // [RULE7] entry needs pin low and battery
   wire learn_ok = f_learn && narrow_voltage_direct_charge && !bgone_sync && battery_present;
   // [RULE6] exit when entry conditions drop, or on low battery when enabled to
   wire learn_exit = !learn_ok || (f_exit_learn && bat_below_min_sys);
   always_comb begin
      learn_nxt = learn_r;
      unique case (learn_r)
         learn_idle: begin
            if (learn_ok && !(f_exit_learn && bat_below_min_sys)) learn_nxt = learn_active;
         end
         learn_active: begin
            if (learn_exit) learn_nxt = learn_idle;
         end
         default: learn_nxt = learn_idle;
      endcase
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) learn_r <= learn_idle;
      else learn_r <= learn_nxt;
   end
   // ==========================================================
   // comparator debounce
   cmp_dbnc_if dbi ();
   assign dbi.sel = f_dbnc;
   assign dbi.raw = cmp_s_r[1];
   cmp_debounce u_dbnc (
      .clk(clk),
      .rst_b(rst_b),
      .d(dbi.dbn)
   );
   // ==========================================================
   // output flops; one cycle of latency keeps outputs glitch free
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vin_loop_en <= 1'b1;
         sys_offset_mv_out <= 9'h000;
         reverse_turbo_active <= 1'b0;
         cmp_asserted <= 1'b0;
         learn_active_out <= 1'b0;
         reverse_output_supply <= 1'b0;
         supplemental_en <= 1'b0;
         switch_khz <= khz_1420;
         battery_fet_gate_off <= 1'b0;
         turbo_allowed <= 1'b1;
         current_monitor_function <= 1'b1;
         mon_sel_battery <= 1'b0;
      end else begin
         vin_loop_en <= vin_en_nxt;
         sys_offset_mv_out <= off_nxt;
         reverse_turbo_active <= rturbo_nxt && !f_bfet_off;
         cmp_asserted <= dbi.out;
         learn_active_out <= (learn_nxt == learn_active);
         // [RULE8] reverse output enable
         reverse_output_supply <= ctrl1_r[rev_out_bit];
         // [RULE9] supplemental enable
         supplemental_en <= ctrl1_r[supp_bit];
         switch_khz <= khz_nxt;
         // [RULE12] gate off overrides turbo
         battery_fet_gate_off <= f_bfet_off;
         turbo_allowed <= !f_bfet_off;
         current_monitor_function <= mon_fn_nxt;
         // [RULE14] monitor source select
         mon_sel_battery <= ctrl1_r[mon_sel_bit];
      end
   end
   // ==========================================================
   // checks
   // [RULE1] loop follows bit
   vin_loop_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
      vin_loop_en == !$past(f_vin_off)) else $error("input loop enable mismatch");
   // [RULE2] offset only idle
   sys_offset_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
      (sys_offset_mv_out != 9'h000) |-> $past(!charging)) else $error("offset applied while charging");
   // [RULE3] turbo needs cause
   rev_turbo_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
      reverse_turbo_active |-> $past(f_rturbo && adapter_overlimit && hybrid_cfg)) else $error("bad turbo");
   // [RULE7] learn entry conditions
   learn_entry_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
      $rose(learn_active_out) |-> $past(battery_present && !bgone_sync)) else $error("bad learn entry");
   // [RULE6] exit on low battery
   learn_exit_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
      (learn_active_out && f_exit_learn && bat_below_min_sys) |=> !learn_active_out) else $error("no learn exit");
   // [RULE12] gate off kills turbo
   fet_off_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE12]
      battery_fet_gate_off |-> (!turbo_allowed && !reverse_turbo_active)) else $error("turbo while fet off");
   // [RULE13] adapter forces monitor
   mon_force_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
      $past(adapter_present) |-> current_monitor_function) else $error("monitor off with adapter");
   // [RULE15] write then read back
   read_back_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE15]
      (reg_wr && sel1 && !reg_rd) ##1 (reg_rd && sel1 && !reg_wr)
      |=> reg_rdata == ($past(reg_wdata, 2) & ctrl_one_mask))
      else $error("readback mismatch");
   // [RULE10] frequency field decode
   freq_decode_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
      ($past(f_freq) == freq_600) |-> switch_khz == khz_600) else $error("frequency decode wrong");
   // [RULE8] reverse output follows bit
   rev_out_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
      reverse_output_supply == $past(ctrl1_r[rev_out_bit])) else $error("reverse output mismatch");
   // [RULE9] supplemental follows bit
   supp_en_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
      supplemental_en == $past(ctrl1_r[supp_bit])) else $error("supplemental enable mismatch");
   // [RULE14] monitor source follows bit
   mon_select_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
      mon_sel_battery == $past(ctrl1_r[mon_sel_bit])) else $error("monitor select mismatch");
   learn_cov_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(learn_active_out));
   exit_cov_c: cover property (@(posedge clk) disable iff (!rst_b) $fell(learn_active_out));
   turbo_cov_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(reverse_turbo_active));
   cmp_cov_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(cmp_asserted));
endmodule : charger_control_config_regs

// ---- core/charger_cfg_pkg.sv ----
// package: offsets, field positions, defaults and timing constants for the charger config bank
package charger_cfg_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ctrl_zero_addr = 8'h39; // first control register
   localparam logic [7:0] ctrl_one_addr = 8'h3c; // second control register
   localparam int data_w = 16;
   // ==========================================================
   // first control register fields
   localparam int vin_reg_off_bit = 2;
   localparam int sys_offset_bit = 1;
   localparam int rev_turbo_bit = 0;
   localparam int sys_offset_mv = 384; // adder in mV when not charging
   localparam logic [15:0] ctrl_zero_rst = 16'h0000;
   // ==========================================================
   // second control register fields
   localparam int dbnc_hi = 15;
   localparam int dbnc_lo = 14;
   localparam int exit_learn_bit = 13;
   localparam int learn_bit = 12;
   localparam int rev_out_bit = 11;
   localparam int supp_bit = 10;
   localparam int freq_hi = 9;
   localparam int freq_lo = 7;
   localparam int bfet_off_bit = 6;
   localparam int mon_off_bit = 5;
   localparam int mon_sel_bit = 4;
   localparam logic [15:0] ctrl_one_rst = 16'h0000;
   // writable mask of the upper fields; lower bits belong to other logic
   localparam logic [15:0] ctrl_one_mask = 16'hfff0;
   // ==========================================================
   // debounce times and derived cycle counts at 250 MHz
   localparam int clk_mhz = 250;
   localparam int dbnc_2us_ns = 2000;
   localparam int dbnc_12us_ns = 12000;
   localparam int dbnc_2ms_ns = 2000000;
   localparam int dbnc_720us_ns = 720000;
   localparam int dbnc_2us_cyc = dbnc_2us_ns * clk_mhz / 1000;
   localparam int dbnc_12us_cyc = dbnc_12us_ns * clk_mhz / 1000;
   localparam int dbnc_2ms_cyc = dbnc_2ms_ns * clk_mhz / 1000;
   localparam int dbnc_720us_cyc = dbnc_720us_ns * clk_mhz / 1000;
   localparam int cnt_w = 20;
   // ==========================================================
   // switching frequency codes in kHz
   localparam logic [2:0] freq_1420 = 3'h0;
   localparam logic [2:0] freq_1180 = 3'h1;
   localparam logic [2:0] freq_1020 = 3'h2;
   localparam logic [2:0] freq_890 = 3'h3;
   localparam logic [2:0] freq_808 = 3'h4;
   localparam logic [2:0] freq_656 = 3'h6;
   localparam logic [2:0] freq_600 = 3'h7;
   localparam logic [10:0] khz_1420 = 11'h58c;
   localparam logic [10:0] khz_1180 = 11'h49c;
   localparam logic [10:0] khz_1020 = 11'h3fc;
   localparam logic [10:0] khz_890 = 11'h37a;
   localparam logic [10:0] khz_808 = 11'h328;
   localparam logic [10:0] khz_656 = 11'h290;
   localparam logic [10:0] khz_600 = 11'h258;
   // learn mode states
   typedef enum logic [1:0] {learn_idle, learn_active} learn_st_t;
endpackage : charger_cfg_pkg

// ---- core/cmp_dbnc_if.sv ----
// interface: comparator debounce request and result between top and debouncer
`timescale 1ns/100ps
interface cmp_dbnc_if;
   logic [1:0] sel; // debounce code from the register
   logic raw; // synchronised comparator level
   logic out; // debounced assertion
   modport ctl (output sel, output raw, input out);
   modport dbn (input sel, input raw, output out);
endinterface : cmp_dbnc_if

// ---- core/cmp_debounce.sv ----
// module: comparator assertion debounce with selectable delay
`timescale 1ns/100ps
module cmp_debounce
   import charger_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   cmp_dbnc_if.dbn d
);
   // ==========================================================
   // delay select
   logic [cnt_w-1:0] cnt_r;
   logic [cnt_w-1:0] cnt_nxt;
   logic out_r;
   wire [cnt_w-1:0] limit;
   // [RULE5] code to cycle count
   assign limit = (d.sel == 2'h0) ? cnt_w'(dbnc_2us_cyc) :
                  (d.sel == 2'h1) ? cnt_w'(dbnc_12us_cyc) :
                  (d.sel == 2'h2) ? cnt_w'(dbnc_2ms_cyc) : cnt_w'(dbnc_720us_cyc);
   // only assertion is delayed; release is immediate
   assign cnt_nxt = !d.raw ? '0 : (cnt_r < limit) ? cnt_r + cnt_w'(1) : cnt_r;
   // ==========================================================
   // counter and output flop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         out_r <= d.raw && (cnt_nxt >= limit);
      end
   end
   assign d.out = out_r;
endmodule : cmp_debounce

// ---- test/host_model.sv ----
// host firmware model driving the charger register bus
`timescale 1ns/100ps
module host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   // ==========================================================
   // bus cycles
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // one-cycle write; data inverted after so stale data is never reused
   task automatic write_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask : write_reg
   // one-cycle read; data taken once the answering edge has landed
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : read_reg
   // write, then read on the very next edge; back to back access
   task automatic write_read(input logic [7:0] a, input logic [15:0] v, output logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_wdata <= ~v;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : write_read
   // turbo held off
   // firmware never asks for reverse turbo while direct charging
   task automatic write_zero(input logic [15:0] v, input logic direct);
      write_reg(8'h39, direct ? (v & 16'hfffe) : v);
   endtask : write_zero
   // frequency written back
   // update the second register but keep the frequency field as read
   task automatic write_one_keep(input logic [15:0] v);
      logic [15:0] cur;
      read_reg(8'h3c, cur);
      write_reg(8'h3c, {v[15:10], cur[9:7], v[6:0]});
   endtask : write_one_keep
endmodule : host_model

// ---- test/charger_control_config_regs_tb.sv ----
// testbench for the charger control register bank
`timescale 1ns/100ps
module charger_control_config_regs_tb;
   // ==========================================================
   // signals
   logic clk, rst_b, reg_wr, reg_rd, charging, hybrid_cfg, adapter_overlimit, adapter_present;
   logic battery_present, battery_absent_pin, narrow_voltage_direct_charge, bat_below_min_sys, cmp_raw;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic vin_loop_en, reverse_turbo_active, cmp_asserted, learn_active_out, reverse_output_supply;
   logic supplemental_en, battery_fet_gate_off, turbo_allowed, current_monitor_function, mon_sel_battery;
   logic [8:0] sys_offset_mv_out;
   logic [10:0] switch_khz;
   int fail_count = 0;
   int compares = 0;
   charger_control_config_regs uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .charging(charging),
      .hybrid_cfg(hybrid_cfg), .adapter_overlimit(adapter_overlimit), .adapter_present(adapter_present),
      .battery_present(battery_present), .battery_absent_pin(battery_absent_pin),
      .narrow_voltage_direct_charge(narrow_voltage_direct_charge), .bat_below_min_sys(bat_below_min_sys),
      .cmp_raw(cmp_raw), .vin_loop_en(vin_loop_en), .sys_offset_mv_out(sys_offset_mv_out),
      .reverse_turbo_active(reverse_turbo_active), .cmp_asserted(cmp_asserted),
      .learn_active_out(learn_active_out), .reverse_output_supply(reverse_output_supply),
      .supplemental_en(supplemental_en), .switch_khz(switch_khz), .battery_fet_gate_off(battery_fet_gate_off),
      .turbo_allowed(turbo_allowed), .current_monitor_function(current_monitor_function),
      .mon_sel_battery(mon_sel_battery));
   host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // ==========================================================
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
         fail_count++;
      end
   endtask : check
   // settle n edges, then step past the edge updates
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic close_out;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // ==========================================================
   // scenarios
   // defaults straight out of reset
   task automatic t_reset;
      host.read_reg(8'h39, d);
      check(d, 16'h0000);
      host.read_reg(8'h3c, d);
      check(d, 16'h0000);
      check({15'h0, vin_loop_en}, 16'h0001);
      check({5'h0, switch_khz}, 16'h058c);
      check({7'h0, sys_offset_mv_out}, 16'h0000);
      check({14'h0, turbo_allowed, battery_fet_gate_off}, 16'h0002);
      check({14'h0, current_monitor_function, mon_sel_battery}, 16'h0002);
      check({13'h0, reverse_output_supply, supplemental_en, learn_active_out}, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   // first register fields, unmapped write and read
   task automatic t_zero;
      @(posedge clk);
      hybrid_cfg <= 1'b1;
      adapter_overlimit <= 1'b1;
      host.write_zero(16'hffff, 1'b0);
      host.write_reg(8'h40, 16'hffff);
      host.read_reg(8'h39, d);
      check(d, 16'h0007);
      host.read_reg(8'h40, d);
      check(d, 16'h0000);
      check({15'h0, vin_loop_en}, 16'h0000);
      check({7'h0, sys_offset_mv_out}, 16'h0180);
      check({15'h0, reverse_turbo_active}, 16'h0001);
      @(posedge clk);
      charging <= 1'b1;
      adapter_overlimit <= 1'b0;
      wait_cyc(3);
      check({7'h0, sys_offset_mv_out}, 16'h0000);
      check({15'h0, reverse_turbo_active}, 16'h0000);
      host.write_zero(16'h0000, 1'b0);
      wait_cyc(2);
      check({15'h0, vin_loop_en}, 16'h0001);
      $display("test first register done");
   endtask : t_zero
   // every frequency code, the unlisted one too
   task automatic t_freq;
      logic [10:0] khz [8] = '{11'h58c, 11'h49c, 11'h3fc, 11'h37a, 11'h328, 11'h328, 11'h290, 11'h258};
      for (int c = 0; c < 8; c++) begin
         host.write_reg(8'h3c, {6'h0, c[2:0], 7'h0});
         wait_cyc(2);
         check({5'h0, switch_khz}, {5'h0, khz[c]});
      end
      $display("test frequency done");
   endtask : t_freq
   // second register flags, turbo interplay, monitor override
   task automatic t_one;
      @(posedge clk);
      charging <= 1'b0;
      adapter_overlimit <= 1'b1;
      host.write_zero(16'h0001, 1'b0);
      host.write_read(8'h3c, 16'hffff, d);
      check(d, 16'hfff0);
      check({13'h0, reverse_output_supply, supplemental_en, mon_sel_battery}, 16'h0007);
      check({13'h0, battery_fet_gate_off, turbo_allowed, reverse_turbo_active}, 16'h0004);
      check({15'h0, current_monitor_function}, 16'h0000);
      @(posedge clk);
      adapter_present <= 1'b1;
      wait_cyc(3);
      check({15'h0, current_monitor_function}, 16'h0001);
      host.write_reg(8'h3c, 16'h0000);
      wait_cyc(2);
      check({13'h0, battery_fet_gate_off, turbo_allowed, reverse_turbo_active}, 16'h0003);
      check({14'h0, supplemental_en, mon_sel_battery}, 16'h0000);
      host.write_zero(16'h0000, 1'b0);
      $display("test second register done");
   endtask : t_one
   // learn entry needs the pin low, exit on low battery only when asked
   task automatic t_learn;
      host.write_reg(8'h3c, 16'h0180);
      @(posedge clk);
      narrow_voltage_direct_charge <= 1'b1;
      host.write_zero(16'h0001, 1'b1);
      host.read_reg(8'h39, d);
      check(d, 16'h0000);
      host.write_one_keep(16'h1000);
      wait_cyc(8);
      check({15'h0, learn_active_out}, 16'h0000);
      check({5'h0, switch_khz}, 16'h037a);
      @(posedge clk);
      battery_absent_pin <= 1'b0;
      wait_cyc(8);
      check({15'h0, learn_active_out}, 16'h0001);
      @(posedge clk);
      bat_below_min_sys <= 1'b1;
      wait_cyc(8);
      check({15'h0, learn_active_out}, 16'h0001);
      host.write_one_keep(16'h3000);
      wait_cyc(4);
      check({15'h0, learn_active_out}, 16'h0000);
      @(posedge clk);
      narrow_voltage_direct_charge <= 1'b0;
      $display("test learn done");
   endtask : t_learn
   // short codes timed, long codes only shown not to assert early
   task automatic t_dbnc;
      int lo [4] = '{480, 2950, 3100, 3100};
      for (int c = 0; c < 4; c++) begin
         host.write_reg(8'h3c, {c[1:0], 14'h0});
         @(posedge clk);
         cmp_raw <= 1'b1;
         wait_cyc(lo[c]);
         check({15'h0, cmp_asserted}, 16'h0000);
         if (c < 2) begin
            wait_cyc(60);
            check({15'h0, cmp_asserted}, 16'h0001);
         end
         @(posedge clk);
         cmp_raw <= 1'b0;
         wait_cyc(8);
         check({15'h0, cmp_asserted}, 16'h0000);
      end
      $display("test debounce done");
   endtask : t_dbnc
   // reset in mid-run brings every field back to its default
   task automatic t_rerst;
      host.write_reg(8'h39, 16'h0007);
      host.write_reg(8'h3c, 16'h0380);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      wait_cyc(1);
      host.read_reg(8'h39, d);
      check(d, 16'h0000);
      host.read_reg(8'h3c, d);
      check(d, 16'h0000);
      check({5'h0, switch_khz}, 16'h058c);
      check({15'h0, vin_loop_en}, 16'h0001);
      $display("test mid-run reset done");
   endtask : t_rerst
   // ==========================================================
   // clock, watchdog, main sequence
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // whole run is near 10000 cycles; 50000 means a hang
   initial begin
      #200000;
      fail_count++;
      close_out;
   end
   initial begin
      {rst_b, charging, hybrid_cfg, adapter_overlimit, adapter_present, battery_present} = 6'h01;
      {narrow_voltage_direct_charge, bat_below_min_sys, cmp_raw} = 3'h0;
      battery_absent_pin = 1'b1;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      wait_cyc(1);
      t_reset;
      t_zero;
      t_freq;
      t_one;
      t_learn;
      t_dbnc;
      t_rerst;
      close_out;
   end
endmodule : charger_control_config_regs_tb
